/* core/cae_pkg.sv */
// shared types and constants of the execute stage for arithmetic, logic and flow
// assumes a single core clock and a decoder that hands over one operation at a time
package cae_pkg;

  // ****************************************
  // operations
  // ****************************************
  typedef enum logic [5:0] {
    add_regs, add_carry, add_imm_word, sub_regs, sub_const, sub_with_borrow,
    sub_const_with_borrow, sub_imm_word, and_regs, and_const, or_regs, or_const,
    xor_regs, set_mask_bits, clear_mask_bits, test_zero_minus, zero_register,
    mult_unsigned, mult_signed, mult_signed_unsigned, frac_mult_unsigned,
    frac_mult_signed, frac_mult_signed_unsigned, rel_jump, ind_jump, direct_jump,
    rel_call, ind_call, sub_return, irq_return, cmp_skip_equal, cmp_regs,
    cmp_with_carry
  } cae_op_e;

  // ****************************************
  // status flags and their positions
  // ****************************************
  typedef struct packed {
    logic i;
    logic t;
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } cae_flags_s;

  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_ARITH = 8'h3f;  // h s v n z c
  localparam logic [7:0] MASK_WORD = 8'h1f;   // s v n z c
  localparam logic [7:0] MASK_LOGIC = 8'h1e;  // s v n z
  localparam logic [7:0] MASK_MUL = 8'h03;    // z c
  localparam logic [7:0] MASK_IRQ = 8'h80;    // i
  localparam logic [7:0] BYTE_ALL_ONES = 8'hff;

  // ****************************************
  // cycle counts
  // ****************************************
  localparam logic [2:0] CYC_ALU = 3'h1;
  localparam logic [2:0] CYC_WORD = 3'h2;
  localparam logic [2:0] CYC_MUL = 3'h2;
  localparam logic [2:0] CYC_JUMP = 3'h2;
  localparam logic [2:0] CYC_DIRECT_JUMP = 3'h3;
  localparam logic [2:0] CYC_CALL = 3'h3;
  localparam logic [2:0] CYC_RETURN = 3'h4;
  localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
  localparam logic [2:0] CYC_SKIP_TWO = 3'h3;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] PC_SKIP_ONE = 16'h0002;
  localparam logic [15:0] PC_SKIP_TWO = 16'h0003;

  // ****************************************
  // request from the decoder and result to the register file
  // ****************************************
  typedef struct packed {
    cae_op_e op;
    logic [7:0] rd;         // destination operand value
    logic [7:0] rr;         // source operand value
    logic [7:0] k;          // byte constant or mask
    logic [5:0] kw;         // word constant 0..63
    logic [15:0] pair;      // register pair high:low
    logic [15:0] zptr;      // z pointer
    logic [15:0] pc;        // address of this instruction
    logic [15:0] target;    // signed relative offset or direct address
    logic next_two_word;    // instruction after this one is two words long
    cae_flags_s flags;      // status register before the operation
  } cae_req_s;

  typedef struct packed {
    logic rd_we;
    logic [7:0] rd_data;
    logic pair_we;
    logic [15:0] pair_data;
    logic prod_we;          // write r1:r0
    logic [15:0] prod_data;
    logic [7:0] flag_we;    // per-flag write enable
    cae_flags_s flags;
    logic [15:0] pc_next;
  } cae_res_s;

endpackage : cae_pkg

/* core/cae_exec.sv */
// execute stage: arithmetic, logic, multiply, compare, skip, jump, call and return
// assumes the decoder holds req steady while start is high and the stack
// answers a pop with pop_data in the cycle that pop_req is high
//
// Overview of operation
// RULE1: add and add-with-carry, six flags, one cycle
// RULE2: word add constant to pair, two cycles
// RULE3: subtract register or constant, one cycle
// RULE4: subtract register with borrow, one cycle
// RULE5: subtract constant with borrow, one cycle
// RULE6: word subtract constant from pair, two cycles
// RULE7: and with register or constant, z n v
// RULE8: or and exclusive or, z n v
// RULE9: set mask bits by or
// RULE10: clear mask bits by and with complement
// RULE11: test and zero register set z n v
// RULE12: three multiplies into r1:r0, z c, two cycles
// RULE13: fractional multiplies shift product left one
// RULE14: indirect jump loads pc from z, two cycles
// RULE15: indirect call pushes return, loads z, three
// RULE16: compare skip equal adds two or three
// RULE17: compare sets flags without writing rd
// RULE18: relative jump two cycles, relative call three
// RULE19: returns pop pc in four, irq sets i
module cae_exec (
  input wire logic mclk,                   // core clock
  input wire logic rst,                    // asynchronous reset, active high
  input wire logic start,                  // request valid, taken when not busy
  input wire cae_pkg::cae_req_s req,       // operation and operands
  input wire logic [15:0] pop_data,        // word popped from the stack
  output logic busy,                       // operation in progress
  output logic done,                       // one-cycle pulse, result valid
  output cae_pkg::cae_res_s result,        // result, held until next done
  output logic push_req,                   // one-cycle push of push_data
  output logic [15:0] push_data,           // return address to push
  output logic pop_req                     // one-cycle pop request
);

  // ****************************************
  // combinational operation
  // ****************************************
  typedef enum {st_idle, st_run} cae_state_e;

  cae_state_e state, next_state;
  logic [2:0] cnt, next_cnt;
  logic pop_wait, next_pop_wait;
  logic next_busy, next_done, next_push_req, next_pop_req;
  logic [15:0] next_push_data;
  cae_pkg::cae_res_s next_result, hold, next_hold, calc;
  logic [2:0] calc_cyc;
  logic calc_push, calc_pop;

  function automatic logic [7:0] arith_flags(input logic [7:0] a, input logic [7:0] b,
                                             input logic [7:0] r, input logic sub,
                                             input logic zkeep, input cae_pkg::cae_flags_s f);
    cae_pkg::cae_flags_s o;
    o = f;
    if (sub) begin
      o.h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      o.v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      o.c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    end else begin
      o.h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
      o.v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
      o.c = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
    end
    o.n = r[7];
    // with borrow, a zero result keeps z only if it was already set
    o.z = (r == 8'h00) & (zkeep ? f.z : 1'b1);
    o.s = o.n ^ o.v;
    return o;
  endfunction : arith_flags

  function automatic logic [7:0] logic_flags(input logic [7:0] r,
                                             input cae_pkg::cae_flags_s f);
    cae_pkg::cae_flags_s o;
    o = f;
    o.v = 1'b0;
    o.n = r[7];
    o.z = (r == 8'h00);
    o.s = r[7];
    return o;
  endfunction : logic_flags

  function automatic logic [15:0] multiply(input logic [7:0] a, input logic [7:0] b,
                                           input logic sa, input logic sb);
    logic signed [8:0] ea;
    logic signed [8:0] eb;
    logic signed [17:0] p;
    ea = $signed({sa & a[7], a});
    eb = $signed({sb & b[7], b});
    p = ea * eb;
    return p[15:0];
  endfunction : multiply

  always_comb begin
    logic [7:0] r8;
    logic [7:0] opb;
    logic [8:0] sum9;
    logic [15:0] r16;
    logic [15:0] prod;
    logic cin;
    logic zkeep;
    logic is_sub;
    logic frac;
    cae_pkg::cae_flags_s f;
    r8 = 8'h00;
    opb = req.rr;
    sum9 = 9'h000;
    r16 = 16'h0000;
    prod = 16'h0000;
    cin = 1'b0;
    zkeep = 1'b0;
    is_sub = 1'b0;
    frac = 1'b0;
    f = req.flags;
    calc = '0;
    calc.flags = req.flags;
    calc.pc_next = req.pc + cae_pkg::PC_STEP;
    calc_cyc = cae_pkg::CYC_ALU;
    calc_push = 1'b0;
    calc_pop = 1'b0;
    unique case (req.op)
      cae_pkg::add_regs, cae_pkg::add_carry, cae_pkg::sub_regs, cae_pkg::sub_const,
      cae_pkg::sub_with_borrow, cae_pkg::sub_const_with_borrow, cae_pkg::cmp_regs,
      cae_pkg::cmp_with_carry: begin
        is_sub = !(req.op inside {cae_pkg::add_regs, cae_pkg::add_carry});
        cin = (req.op inside {cae_pkg::add_carry, cae_pkg::sub_with_borrow,
                              cae_pkg::sub_const_with_borrow, cae_pkg::cmp_with_carry})
              & req.flags.c;
        zkeep = req.op inside {cae_pkg::sub_with_borrow, cae_pkg::sub_const_with_borrow,
                               cae_pkg::cmp_with_carry};
        if (req.op inside {cae_pkg::sub_const, cae_pkg::sub_const_with_borrow}) begin
          opb = req.k;
        end
        if (is_sub) begin
          sum9 = {1'b0, req.rd} - {1'b0, opb} - {8'h00, cin};  // see RULE3 see RULE4 see RULE5
        end else begin
          sum9 = {1'b0, req.rd} + {1'b0, opb} + {8'h00, cin};  // see RULE1
        end
        r8 = sum9[7:0];
        calc.flags = arith_flags(req.rd, opb, r8, is_sub, zkeep, req.flags);
        calc.flag_we = cae_pkg::MASK_ARITH;
        // compares only touch the flags
        calc.rd_we = !(req.op inside {cae_pkg::cmp_regs, cae_pkg::cmp_with_carry});  // see RULE17
        calc.rd_data = r8;
      end
      cae_pkg::add_imm_word, cae_pkg::sub_imm_word: begin
        if (req.op == cae_pkg::add_imm_word) begin
          r16 = req.pair + {10'h000, req.kw};  // see RULE2
          f.v = ~req.pair[15] & r16[15];
          f.c = ~r16[15] & req.pair[15];
        end else begin
          r16 = req.pair - {10'h000, req.kw};  // see RULE6
          f.v = req.pair[15] & ~r16[15];
          f.c = r16[15] & ~req.pair[15];
        end
        f.n = r16[15];
        f.z = (r16 == 16'h0000);
        f.s = f.n ^ f.v;
        calc.flags = f;
        calc.flag_we = cae_pkg::MASK_WORD;
        calc.pair_we = 1'b1;
        calc.pair_data = r16;
        calc_cyc = cae_pkg::CYC_WORD;  // see RULE2 see RULE6
      end
      cae_pkg::and_regs, cae_pkg::and_const, cae_pkg::or_regs, cae_pkg::or_const,
      cae_pkg::xor_regs, cae_pkg::set_mask_bits, cae_pkg::clear_mask_bits,
      cae_pkg::test_zero_minus, cae_pkg::zero_register: begin
        unique case (req.op)
          cae_pkg::and_regs: r8 = req.rd & req.rr;  // see RULE7
          cae_pkg::and_const: r8 = req.rd & req.k;  // see RULE7
          cae_pkg::or_regs: r8 = req.rd | req.rr;  // see RULE8
          cae_pkg::or_const: r8 = req.rd | req.k;  // see RULE8
          cae_pkg::xor_regs: r8 = req.rd ^ req.rr;  // see RULE8
          cae_pkg::set_mask_bits: r8 = req.rd | req.k;  // see RULE9
          cae_pkg::clear_mask_bits: r8 = req.rd & (cae_pkg::BYTE_ALL_ONES - req.k);  // see RULE10
          cae_pkg::test_zero_minus: r8 = req.rd & req.rd;  // see RULE11
          default: r8 = req.rd ^ req.rd;  // see RULE11
        endcase
        calc.flags = logic_flags(r8, req.flags);
        calc.flag_we = cae_pkg::MASK_LOGIC;
        calc.rd_we = 1'b1;
        calc.rd_data = r8;
      end
      cae_pkg::mult_unsigned, cae_pkg::mult_signed, cae_pkg::mult_signed_unsigned,
      cae_pkg::frac_mult_unsigned, cae_pkg::frac_mult_signed,
      cae_pkg::frac_mult_signed_unsigned: begin
        frac = req.op inside {cae_pkg::frac_mult_unsigned, cae_pkg::frac_mult_signed,
                              cae_pkg::frac_mult_signed_unsigned};
        prod = multiply(req.rd, req.rr,
                        req.op inside {cae_pkg::mult_signed, cae_pkg::mult_signed_unsigned,
                                       cae_pkg::frac_mult_signed,
                                       cae_pkg::frac_mult_signed_unsigned},
                        req.op inside {cae_pkg::mult_signed, cae_pkg::frac_mult_signed});
        // carry is the product msb before the fractional shift
        f.c = prod[15];  // see RULE12
        r16 = frac ? {prod[14:0], 1'b0} : prod;  // see RULE13
        f.z = (r16 == 16'h0000);
        calc.flags = f;
        calc.flag_we = cae_pkg::MASK_MUL;
        calc.prod_we = 1'b1;
        calc.prod_data = r16;
        calc_cyc = cae_pkg::CYC_MUL;  // see RULE12 see RULE13
      end
      cae_pkg::rel_jump, cae_pkg::rel_call: begin
        calc.pc_next = req.pc + req.target + cae_pkg::PC_STEP;  // see RULE18
        calc_push = (req.op == cae_pkg::rel_call);
        calc_cyc = calc_push ? cae_pkg::CYC_CALL : cae_pkg::CYC_JUMP;  // see RULE18
      end
      cae_pkg::ind_jump, cae_pkg::ind_call: begin
        calc.pc_next = req.zptr;  // see RULE14 see RULE15
        calc_push = (req.op == cae_pkg::ind_call);  // see RULE15
        calc_cyc = calc_push ? cae_pkg::CYC_CALL : cae_pkg::CYC_JUMP;  // see RULE14 see RULE15
      end
      cae_pkg::direct_jump: begin
        calc.pc_next = req.target;
        calc_cyc = cae_pkg::CYC_DIRECT_JUMP;
      end
      cae_pkg::sub_return, cae_pkg::irq_return: begin
        calc_pop = 1'b1;  // see RULE19
        calc_cyc = cae_pkg::CYC_RETURN;  // see RULE19
        if (req.op == cae_pkg::irq_return) begin
          f.i = 1'b1;  // see RULE19
          calc.flags = f;
          calc.flag_we = cae_pkg::MASK_IRQ;
        end
      end
      cae_pkg::cmp_skip_equal: begin
        // a skip costs one cycle per word of the skipped instruction
        if (req.rd == req.rr) begin
          calc.pc_next = req.pc + (req.next_two_word ? cae_pkg::PC_SKIP_TWO
                                                     : cae_pkg::PC_SKIP_ONE);  // see RULE16
          calc_cyc = req.next_two_word ? cae_pkg::CYC_SKIP_TWO : cae_pkg::CYC_SKIP_ONE;  // see RULE16
        end
      end
      default: begin
        calc = '0;
        calc.flags = req.flags;
        calc.pc_next = req.pc + cae_pkg::PC_STEP;
      end
    endcase
  end

  // ****************************************
  // sequencing
  // ****************************************
  // results are held internally and released together on the last cycle,
  // so the register file never sees a half-finished multi-cycle operation
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_hold = hold;
    next_pop_wait = 1'b0;
    next_result = result;
    next_done = 1'b0;
    next_busy = busy;
    next_push_req = 1'b0;
    next_push_data = push_data;
    next_pop_req = 1'b0;
    unique case (state)
      st_idle: begin
        if (start) begin
          next_push_req = calc_push;  // see RULE15 see RULE18
          next_push_data = req.pc + cae_pkg::PC_STEP;
          next_pop_req = calc_pop;  // see RULE19
          next_pop_wait = calc_pop;
          if (calc_cyc == cae_pkg::CYC_ALU) begin
            next_result = calc;
            next_done = 1'b1;
          end else begin
            next_hold = calc;
            next_cnt = calc_cyc - 3'h1;
            next_busy = 1'b1;
            next_state = st_run;
          end
        end
      end
      st_run: begin
        if (pop_wait) begin
          next_hold.pc_next = pop_data;  // see RULE19
        end
        next_cnt = cnt - 3'h1;
        if (cnt == 3'h1) begin
          next_result = next_hold;
          next_done = 1'b1;
          next_busy = 1'b0;
          next_state = st_idle;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      cnt <= 3'h0;
      hold <= '0;
      pop_wait <= 1'b0;
      result <= '0;
      done <= 1'b0;
      busy <= 1'b0;
      push_req <= 1'b0;
      push_data <= 16'h0000;
      pop_req <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      hold <= next_hold;
      pop_wait <= next_pop_wait;
      result <= next_result;
      done <= next_done;
      busy <= next_busy;
      push_req <= next_push_req;
      push_data <= next_push_data;
      pop_req <= next_pop_req;
    end
  end

endmodule : cae_exec

/* dv/cae_exec_asserts.sv */
// concurrent checks on the execute stage, seen from its ports only
// assumes one clock, asynchronous active-high reset, bound onto every cae_exec
module cae_exec_asserts (
  input wire logic mclk, // core clock
  input wire logic rst, // reset
  input wire logic start, // request valid
  input wire cae_pkg::cae_req_s req, // request
  input wire logic [15:0] pop_data, // stack word
  input wire logic busy, // in progress
  input wire logic done, // result pulse
  input wire cae_pkg::cae_res_s result, // result
  input wire logic push_req, // push pulse
  input wire logic [15:0] push_data, // pushed word
  input wire logic pop_req // pop pulse
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_take(cae_pkg::cae_op_e o);
    start && !busy && req.op == o;
  endsequence
  a_add_one: assert property (
    s_take(cae_pkg::add_regs) |=> done && result.flag_we == 8'h3f
    && result.rd_data == $past(req.rd) + $past(req.rr)) else $error("add result wrong");
  a_word_two: assert property (
    s_take(cae_pkg::add_imm_word) |=> busy && !done ##1 done && !busy && result.pair_we)
    else $error("word add timing wrong");
  a_word_sub: assert property (
    s_take(cae_pkg::sub_imm_word) |=> !done ##1 done
    && result.pair_data == $past(req.pair, 2) - 16'($past(req.kw, 2)))
    else $error("word subtract wrong");
  a_and_mask: assert property (
    s_take(cae_pkg::and_regs) |=> result.flag_we == 8'h1e
    && result.rd_data == ($past(req.rd) & $past(req.rr))) else $error("and result wrong");
  a_mul_two: assert property (
    s_take(cae_pkg::mult_unsigned) |=> !done ##1 done && result.prod_we
    && result.prod_data == 16'($past(req.rd, 2)) * 16'($past(req.rr, 2)))
    else $error("multiply wrong");
  a_ind_jump_two: assert property (
    s_take(cae_pkg::ind_jump) |=> !done ##1 done && result.flag_we == 8'h00
    && result.pc_next == $past(req.zptr, 2)) else $error("indirect jump wrong");
  a_call_push: assert property (
    s_take(cae_pkg::ind_call) |=> push_req && push_data == $past(req.pc) + 16'h0001
    ##2 done && result.pc_next == $past(req.zptr, 3)) else $error("indirect call wrong");
  a_ret_four: assert property (
    s_take(cae_pkg::sub_return) |=> pop_req ##1 !done [*2] ##1 done
    && result.pc_next == $past(pop_data, 3)) else $error("return wrong");
  a_skip_one: assert property (
    s_take(cae_pkg::cmp_skip_equal) ##0 (req.rd == req.rr && !req.next_two_word)
    |=> !done ##1 done && result.pc_next == $past(req.pc, 2) + 16'h0002)
    else $error("skip wrong");
  a_push_pulse: assert property (push_req |=> !push_req) else $error("push held");
  a_add_flags: assert property (
    s_take(cae_pkg::add_carry) |=> result.flags.n == result.rd_data[7]
    && result.flags.v == ($past(req.rd[7]) == $past(req.rr[7])
                          && $past(req.rd[7]) != result.rd_data[7])
    && result.flags.s == (result.flags.n ^ result.flags.v)
    && result.flags.h == (({1'b0, $past(req.rd[3:0])} + {1'b0, $past(req.rr[3:0])}
                          + {4'h0, $past(req.flags.c)}) >= 5'h10))
    else $error("add flags wrong");
  a_irq_ret_ie: assert property (
    s_take(cae_pkg::irq_return) |=> !done [*3] ##1 done && result.flags.i
    && result.flag_we == 8'h80) else $error("interrupt return flag wrong");
endmodule : cae_exec_asserts

bind cae_exec cae_exec_asserts u_asserts (.mclk(mclk), .rst(rst), .start(start), .req(req),
  .pop_data(pop_data), .busy(busy), .done(done), .result(result), .push_req(push_req),
  .push_data(push_data), .pop_req(pop_req));

/* dv/cae_stack_model.sv */
// stack beside the register file: keeps pushed return addresses, answers pops
// assumes one push or pop per cycle; pop_data is combinational in the pop cycle
module cae_stack_model (
  input wire logic mclk, // core clock
  input wire logic rst, // reset
  input wire logic push_req, // push pulse
  input wire logic [15:0] push_data, // word to keep
  input wire logic pop_req, // pop pulse
  output logic [15:0] pop_data // top word while popping
);
  logic [15:0] mem [0:7];
  logic [2:0] sp;
  logic [15:0] last;
  // outside a pop the word toggles so a late sample never looks valid
  assign pop_data = pop_req ? mem[sp - 3'h1] : ~last;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sp <= 3'h0;
      last <= 16'h0000;
    end else begin
      last <= pop_data;
      if (push_req) begin
        mem[sp] <= push_data;
        sp <= sp + 3'h1;
      end else if (pop_req) begin
        sp <= sp - 3'h1;
      end
    end
  end
endmodule : cae_stack_model

/* dv/cae_exec_tb_top.sv */
// self-checking bench of the execute stage with a stack model on the far side
// assumes the bench drives every request; expectations are worked out by hand
module cae_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // sel: 0 rd, 1 pair, 2 product, 3 pc_next
  typedef struct {
    cae_pkg::cae_op_e op;
    logic [15:0] a, b;
    logic cin, tw;
    logic [1:0] sel;
    logic [15:0] exp;
    logic [7:0] we;
    logic [1:0] zc;
    logic [2:0] cyc;
  } cae_row_s;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  cae_pkg::cae_req_s req = '0;
  logic [15:0] pop_data, push_data;
  logic busy, done, push_req, pop_req;
  cae_pkg::cae_res_s result;
  int errors = 0;
  int compares = 0;
  int n;
  cae_row_s rows [$] = '{
    '{cae_pkg::add_regs, 16'h00ff, 16'h0001, 0, 0, 0, 16'h0000, 8'h3f, 2'h3, 1},
    '{cae_pkg::add_carry, 16'h000f, 16'h0000, 1, 0, 0, 16'h0010, 8'h3f, 2'h0, 1},
    '{cae_pkg::sub_regs, 16'h0005, 16'h0005, 0, 0, 0, 16'h0000, 8'h3f, 2'h2, 1},
    '{cae_pkg::sub_const, 16'h0000, 16'h0001, 0, 0, 0, 16'h00ff, 8'h3f, 2'h1, 1},
    '{cae_pkg::sub_with_borrow, 16'h0005, 16'h0004, 1, 0, 0, 16'h0000, 8'h3f, 2'h2, 1},
    '{cae_pkg::sub_const_with_borrow, 16'h0, 16'h0, 1, 0, 0, 16'h00ff, 8'h3f, 2'h1, 1},
    '{cae_pkg::and_regs, 16'h00f0, 16'h000f, 0, 0, 0, 16'h0000, 8'h1e, 2'h2, 1},
    '{cae_pkg::and_const, 16'h00f0, 16'h00ff, 0, 0, 0, 16'h00f0, 8'h1e, 2'h0, 1},
    '{cae_pkg::or_regs, 16'h0000, 16'h0000, 0, 0, 0, 16'h0000, 8'h1e, 2'h2, 1},
    '{cae_pkg::or_const, 16'h0080, 16'h0001, 0, 0, 0, 16'h0081, 8'h1e, 2'h0, 1},
    '{cae_pkg::xor_regs, 16'h005a, 16'h005a, 0, 0, 0, 16'h0000, 8'h1e, 2'h2, 1},
    '{cae_pkg::set_mask_bits, 16'h0001, 16'h0080, 0, 0, 0, 16'h0081, 8'h1e, 2'h0, 1},
    '{cae_pkg::clear_mask_bits, 16'h00ff, 16'h000f, 0, 0, 0, 16'h00f0, 8'h1e, 2'h0, 1},
    '{cae_pkg::test_zero_minus, 16'h0000, 16'h0000, 0, 0, 0, 16'h0000, 8'h1e, 2'h2, 1},
    '{cae_pkg::zero_register, 16'h00a5, 16'h0000, 0, 0, 0, 16'h0000, 8'h1e, 2'h2, 1},
    '{cae_pkg::cmp_regs, 16'h0003, 16'h0003, 0, 0, 3, 16'h0004, 8'h3f, 2'h2, 1},
    '{cae_pkg::cmp_with_carry, 16'h0003, 16'h0002, 1, 0, 3, 16'h0004, 8'h3f, 2'h2, 1},
    '{cae_pkg::add_imm_word, 16'hffff, 16'h0001, 0, 0, 1, 16'h0000, 8'h1f, 2'h3, 2},
    '{cae_pkg::sub_imm_word, 16'h0000, 16'h0001, 0, 0, 1, 16'hffff, 8'h1f, 2'h1, 2},
    '{cae_pkg::mult_unsigned, 16'h00ff, 16'h00ff, 0, 0, 2, 16'hfe01, 8'h03, 2'h1, 2},
    '{cae_pkg::mult_signed, 16'h00ff, 16'h00ff, 0, 0, 2, 16'h0001, 8'h03, 2'h0, 2},
    '{cae_pkg::mult_signed_unsigned, 16'h00ff, 16'h0002, 0, 0, 2, 16'hfffe, 8'h03, 2'h1, 2},
    '{cae_pkg::frac_mult_unsigned, 16'h0080, 16'h0080, 0, 0, 2, 16'h8000, 8'h03, 2'h0, 2},
    '{cae_pkg::frac_mult_signed, 16'h0040, 16'h0040, 0, 0, 2, 16'h2000, 8'h03, 2'h0, 2},
    '{cae_pkg::frac_mult_signed_unsigned, 16'hff, 16'h2, 0, 0, 2, 16'hfffc, 8'h03, 2'h1, 2},
    '{cae_pkg::rel_jump, 16'h0010, 16'hfff0, 0, 0, 3, 16'h0001, 8'h00, 2'h0, 2},
    '{cae_pkg::ind_jump, 16'h0010, 16'h0000, 0, 0, 3, 16'h1234, 8'h00, 2'h0, 2},
    '{cae_pkg::direct_jump, 16'h0010, 16'h0400, 0, 0, 3, 16'h0400, 8'h00, 2'h0, 3},
    '{cae_pkg::rel_call, 16'h0010, 16'h0005, 0, 0, 3, 16'h0016, 8'h00, 2'h0, 3},
    '{cae_pkg::ind_call, 16'h0020, 16'h0000, 0, 0, 3, 16'h1234, 8'h00, 2'h0, 3},
    '{cae_pkg::irq_return, 16'h0000, 16'h0000, 0, 0, 3, 16'h0021, 8'h80, 2'h0, 4},
    '{cae_pkg::sub_return, 16'h0000, 16'h0000, 0, 0, 3, 16'h0011, 8'h00, 2'h0, 4},
    '{cae_pkg::cmp_skip_equal, 16'h0007, 16'h0007, 0, 0, 3, 16'h0009, 8'h00, 2'h0, 2},
    '{cae_pkg::cmp_skip_equal, 16'h0007, 16'h0007, 0, 1, 3, 16'h000a, 8'h00, 2'h0, 3},
    '{cae_pkg::cmp_skip_equal, 16'h0007, 16'h0008, 0, 1, 3, 16'h0008, 8'h00, 2'h0, 1}};
  always #2 mclk = ~mclk;
  cae_exec u_dut (.mclk(mclk), .rst(rst), .start(start), .req(req), .pop_data(pop_data),
    .busy(busy), .done(done), .result(result), .push_req(push_req), .push_data(push_data),
    .pop_req(pop_req));
  cae_stack_model u_stack (.mclk(mclk), .rst(rst), .push_req(push_req),
    .push_data(push_data), .pop_req(pop_req), .pop_data(pop_data));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic go(input cae_row_s w, input logic hold);
    @(posedge mclk);
    start <= 1'b1;
    req.op <= w.op;
    req.rd <= w.a[7:0];
    req.rr <= w.b[7:0];
    req.k <= w.b[7:0];
    req.kw <= w.b[5:0];
    req.pair <= w.a;
    req.pc <= w.a;
    req.zptr <= 16'h1234;
    req.target <= w.b;
    req.next_two_word <= w.tw;
    req.flags <= cae_pkg::cae_flags_s'({6'h00, 1'b1, w.cin});
    @(posedge mclk);
    start <= hold;
    n = 1;
    #1;
    while (done !== 1'b1 && n < 8) begin
      @(posedge mclk);
      start <= 1'b0;
      n++;
      #1;
    end
    if (n == 8) begin
      errors++;
      test_done();
    end
  endtask : go
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge mclk);
    #1 chk({busy, done, push_req, pop_req}, 16'h0000);
    chk(result.pc_next, 16'h0000);
    @(posedge mclk) rst <= 1'b0;
    foreach (rows[i]) begin
      go(rows[i], 1'b0);
      chk(16'(n), 16'(rows[i].cyc));
      chk(rows[i].sel == 0 ? {8'h00, result.rd_data} : rows[i].sel == 1 ? result.pair_data
        : rows[i].sel == 2 ? result.prod_data : result.pc_next, rows[i].exp);
      chk({result.rd_we, result.pair_we, result.prod_we},
        rows[i].sel == 3 ? 16'h0 : 16'h4 >> rows[i].sel);
      chk(result.flag_we, rows[i].we);
      chk({result.flags.z & result.flag_we[1], result.flags.c & result.flag_we[0]},
        rows[i].zc);
      if (rows[i].op inside {cae_pkg::rel_call, cae_pkg::ind_call})
        chk(push_data, rows[i].a + 16'h0001);
    end
    // a start held into the second cycle of a three-cycle call is ignored while busy
    go(rows[29], 1'b1);
    chk(16'(n), 16'h0003);
    chk({result.rd_we, result.pc_next[14:0]}, 16'h1234);
    @(posedge mclk) #1 chk({done, busy}, 16'h0000);
    // reset in mid-call clears busy, done, push_req, pop_req and result.pc_next
    @(posedge mclk);
    start <= 1'b1;
    req.op <= cae_pkg::rel_call;
    @(posedge mclk) start <= 1'b0;
    @(posedge mclk) rst <= 1'b1;
    #1 chk({busy, done, push_req, pop_req}, 16'h0000);
    chk(result.pc_next, 16'h0000);
    @(posedge mclk) rst <= 1'b0;
    repeat (4) @(posedge mclk);
    #1 chk({busy, done}, 16'h0000);
    test_done();
  end
endmodule : cae_exec_tb_top
